// File: dpg_cfg.svh
// Register offsets, reset values and fixed codes for the dual GPIO port block
`ifndef DPG_CFG_SVH
`define DPG_CFG_SVH

`define DPG_ADDR_P0_DATA 8'h80
`define DPG_ADDR_P1_DATA 8'h90
`define DPG_ADDR_PORT_ZERO_DRIVE_STRENGTH 8'h93
`define DPG_ADDR_PORT_ZERO_DIRECTION 8'h94
`define DPG_ADDR_PORT_ZERO_ALTERNATE_SELECT 8'h95
`define DPG_ADDR_PORT_ONE_DIRECTION 8'h96
`define DPG_ADDR_PORT_ONE_ALTERNATE_SELECT 8'h97

`define DPG_RST_P0_DATA 8'hff
`define DPG_RST_PORT_ZERO_DRIVE_STRENGTH 8'h00
`define DPG_RST_PORT_ZERO_DIRECTION 8'hff
`define DPG_RST_PORT_ZERO_ALTERNATE_SELECT 8'h00
`define DPG_RST_P1_DATA 4'hf
`define DPG_RST_PORT_ONE_DIRECTION 4'h4
`define DPG_RST_PORT_ONE_ALTERNATE_SELECT 4'h0

`define DPG_SPI_ROUTE_BOOT 2'h1

// Port 1 pin positions
`define DPG_P1_SCK 0
`define DPG_P1_MOSI 1
`define DPG_P1_MISO 2
`define DPG_P1_CS 3

// Port 1 as SPI master: clock, data out and select driven, data in floating
`define DPG_P1_SPI_OE 4'hb
`define DPG_RST_P1_OUT 4'h8

// Odd pins source, even pins sink
`define DPG_ODD_MASK 8'haa
`define DPG_EVEN_MASK 8'h55

`endif

// File: dpg_gpio_top.sv
// Dual GPIO port block: port 0 pin mux, port 1 SPI/GPIO pins and their registers
`timescale 1ns/100ps
`default_nettype none
`include "dpg_cfg.svh"

module dpg_gpio_top (
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // Special function register access from the CPU core
    input wire logic [7:0] SFR_ADDR,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_WDATA,
    output logic [7:0] SFR_RDATA,
    // SPI routing field held by the SPI block
    input wire logic [1:0] SPI_ROUTE,
    // Port 0 pins
    input wire logic [7:0] P0_IN,
    output logic [7:0] P0_OUT,
    output logic [7:0] P0_OE,
    output logic [7:0] P0_HI_SOURCE,
    output logic [7:0] P0_HI_SINK,
    // Port 1 pins
    input wire logic [3:0] P1_IN,
    output logic [3:0] P1_OUT,
    output logic [3:0] P1_OE,
    // Peripheral outputs routed to pins
    input wire logic GENERAL_TIMER_OUTPUT,
    input wire logic UART_TX,
    input wire logic PWM_OUT,
    input wire logic SPI_SCK,
    input wire logic SPI_MOSI,
    // Pin levels routed to peripherals
    output logic UART_RX,
    output logic EXTERNAL_INTERRUPT_A,
    output logic EXTERNAL_INTERRUPT_B,
    output logic TIMER_A_INPUT,
    output logic TIMER_B_INPUT,
    output logic TIMER_C_INPUT,
    output logic SPI_MISO
);

    dpg_pkg::dpg_p0_cfg_t p0_cfg;
    dpg_pkg::dpg_p1_cfg_t p1_cfg;
    dpg_pkg::dpg_p1_drive_t p1_drive;
    // Decoded pad settings, registered at the next edge
    logic [7:0] next_p0_oe;
    logic [7:0] next_p0_out;

    // Pins whose alternate use drives the pad; bit 1 is left to its direction bit
    function automatic logic p0_pin_is_output(input logic alt, input logic dir, input int idx);
        logic drives;
        drives = 1'b0;
        if (!alt || idx == 1) begin
            drives = !dir;
        end else begin
            drives = (idx == 0) || (idx == 2) || (idx == 7);
        end
        return drives;
    endfunction : p0_pin_is_output

    // Pin level seen by a peripheral only while the pin is in alternate use
    function automatic logic alt_input(input logic alt, input logic pin, input logic idle);
        return alt ? pin : idle;
    endfunction : alt_input

    // Register file; read data comes out of a register one edge after the strobe
    dpg_sfr_regs u_regs (
        .clk(MCLK),
        .rst_n(RST_N),
        .addr(SFR_ADDR),
        .wr(SFR_WR),
        .rd(SFR_RD),
        .wdata(SFR_WDATA),
        .rdata(SFR_RDATA),
        .p0_cfg(p0_cfg),
        .p1_cfg(p1_cfg)
    );

    // Port 1 routing is decoded apart so the SPI override stays in one place
    dpg_port1_mux u_p1_mux (
        .spi_route(SPI_ROUTE),
        .p1_cfg(p1_cfg),
        .spi_sck(SPI_SCK),
        .spi_mosi(SPI_MOSI),
        .drive(p1_drive)
    );

    // Port 0 decode: direction per pin, then the peripheral outputs that take over the latch
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            next_p0_oe[i] = p0_pin_is_output(p0_cfg.alt[i], p0_cfg.dir[i], i);
        end
        next_p0_out = p0_cfg.data;
        if (p0_cfg.alt[0]) begin
            next_p0_out[0] = GENERAL_TIMER_OUTPUT;
        end
        if (p0_cfg.alt[2]) begin
            next_p0_out[2] = UART_TX;
        end
        if (p0_cfg.alt[7]) begin
            next_p0_out[7] = PWM_OUT;
        end
    end

    // Pads sit one register behind the settings so every pin is glitch free
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            P0_OE <= 8'h00;
            P0_OUT <= `DPG_RST_P0_DATA;
        end else begin
            P0_OE <= next_p0_oe;
            P0_OUT <= next_p0_out;
        end
    end

    // Source and sink strength are split by pin parity, one enable per pin
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            P0_HI_SOURCE <= 8'h00;
            P0_HI_SINK <= 8'h00;
        end else begin
            P0_HI_SOURCE <= p0_cfg.drv & `DPG_ODD_MASK;
            P0_HI_SINK <= p0_cfg.drv & `DPG_EVEN_MASK;
        end
    end

    // Reset state is the SPI master setup regardless of the routing input
    // A routing change shows on the pads one edge later, like every other setting
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            P1_OE <= `DPG_P1_SPI_OE;
            P1_OUT <= `DPG_RST_P1_OUT;
        end else begin
            P1_OE <= p1_drive.oe;
            P1_OUT <= p1_drive.out;
        end
    end

    // Interrupt lines are active low, so a disconnected one idles high
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            UART_RX <= 1'b1;
            EXTERNAL_INTERRUPT_A <= 1'b1;
            EXTERNAL_INTERRUPT_B <= 1'b1;
            TIMER_A_INPUT <= 1'b0;
            TIMER_B_INPUT <= 1'b0;
        end else begin
            UART_RX <= alt_input(p0_cfg.alt[1], P0_IN[1], 1'b1);
            EXTERNAL_INTERRUPT_A <= alt_input(p0_cfg.alt[3], P0_IN[3], 1'b1);
            EXTERNAL_INTERRUPT_B <= alt_input(p0_cfg.alt[4], P0_IN[4], 1'b1);
            TIMER_A_INPUT <= alt_input(p0_cfg.alt[5], P0_IN[5], 1'b0);
            TIMER_B_INPUT <= alt_input(p0_cfg.alt[6], P0_IN[6], 1'b0);
        end
    end

    // Data input pin is passed on in every routing; the SPI engine ignores it when idle
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            TIMER_C_INPUT <= 1'b0;
            SPI_MISO <= 1'b1;
        end else begin
            TIMER_C_INPUT <= alt_input(p1_drive.timer_c_en, P1_IN[`DPG_P1_SCK], 1'b0);
            SPI_MISO <= P1_IN[`DPG_P1_MISO];
        end
    end

    // Helper: set once software has written the port 0 direction or alternate select register
    logic cfg_touched;
    always_ff @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            cfg_touched <= 1'b0;
        end else if (SFR_WR && (SFR_ADDR == `DPG_ADDR_PORT_ZERO_DIRECTION || SFR_ADDR == `DPG_ADDR_PORT_ZERO_ALTERNATE_SELECT)) begin
            cfg_touched <= 1'b1;
        end
    end

    // Checks see pre-edge values, so each |=> pairs a pad with the settings one edge earlier
    // Reset checks run without disable iff so the release edge itself is covered
    property p_reset_inputs;
        @(posedge MCLK) $rose(RST_N) |-> (P0_OE == 8'h00) && (P1_OE == `DPG_P1_SPI_OE);
    endproperty
    a_reset_inputs: assert property (p_reset_inputs) else $error("Pins not in reset setup");

    property p_hold_until_write;
        @(posedge MCLK) disable iff (!RST_N) !cfg_touched |-> P0_OE == 8'h00;
    endproperty
    a_hold_until_write: assert property (p_hold_until_write) else $error("Port 0 left input before write");

    property p_alt_drives;
        @(posedge MCLK) disable iff (!RST_N) p0_cfg.alt[0] && p0_cfg.alt[3] |=> P0_OE[0] && !P0_OE[3];
    endproperty
    a_alt_drives: assert property (p_alt_drives) else $error("Alternate use did not set direction");

    property p_rx_dir;
        @(posedge MCLK) disable iff (!RST_N) p0_cfg.alt[1] |=> P0_OE[1] == !$past(p0_cfg.dir[1]);
    endproperty
    a_rx_dir: assert property (p_rx_dir) else $error("Receive pin ignored its direction bit");

    property p_int_gate;
        @(posedge MCLK) disable iff (!RST_N) !p0_cfg.alt[3] ##1 !$past(p0_cfg.alt[3]) |-> EXTERNAL_INTERRUPT_A;
    endproperty
    a_int_gate: assert property (p_int_gate) else $error("Interrupt passed without alternate select");

    property p_gpio_dir;
        @(posedge MCLK) disable iff (!RST_N) !p0_cfg.alt[5] |=> P0_OE[5] == !$past(p0_cfg.dir[5]);
    endproperty
    a_gpio_dir: assert property (p_gpio_dir) else $error("GPIO pin direction wrong");

    property p_tx_value;
        @(posedge MCLK) disable iff (!RST_N) p0_cfg.alt[2] |=> P0_OUT[2] == $past(UART_TX);
    endproperty
    a_tx_value: assert property (p_tx_value) else $error("Transmit pin not fed by UART");

    property p_drive_split;
        @(posedge MCLK) disable iff (!RST_N) ##1 P0_HI_SOURCE == ($past(p0_cfg.drv) & `DPG_ODD_MASK)
            && P0_HI_SINK == ($past(p0_cfg.drv) & `DPG_EVEN_MASK);
    endproperty
    a_drive_split: assert property (p_drive_split) else $error("Drive strength split wrong");

    property p_miso_input;
        @(posedge MCLK) disable iff (!RST_N) !P1_OE[`DPG_P1_MISO];
    endproperty
    a_miso_input: assert property (p_miso_input) else $error("Data input pin driven");

    property p_spi_boot;
        @(posedge MCLK) disable iff (!RST_N) SPI_ROUTE == `DPG_SPI_ROUTE_BOOT
            |=> P1_OE == `DPG_P1_SPI_OE && P1_OUT[`DPG_P1_SCK] == $past(SPI_SCK);
    endproperty
    a_spi_boot: assert property (p_spi_boot) else $error("Port 1 not SPI master in boot route");

    property p_timer_c;
        @(posedge MCLK) disable iff (!RST_N) SPI_ROUTE != `DPG_SPI_ROUTE_BOOT && p1_cfg.alt[0]
            |=> !P1_OE[`DPG_P1_SCK] && TIMER_C_INPUT == $past(P1_IN[`DPG_P1_SCK]);
    endproperty
    a_timer_c: assert property (p_timer_c) else $error("Clock pin not timer input");

    property p_p1_gpio_dir;
        @(posedge MCLK) disable iff (!RST_N) SPI_ROUTE != `DPG_SPI_ROUTE_BOOT
            |=> P1_OE[3] == !$past(p1_cfg.dir[3]) && P1_OE[1] == !$past(p1_cfg.dir[1]);
    endproperty
    a_p1_gpio_dir: assert property (p_p1_gpio_dir) else $error("Port 1 GPIO direction wrong");

    property p_p1_narrow;
        @(posedge MCLK) disable iff (!RST_N) SFR_RD && SFR_ADDR == `DPG_ADDR_PORT_ONE_DIRECTION |=> SFR_RDATA[7:4] == 4'h0;
    endproperty
    a_p1_narrow: assert property (p_p1_narrow) else $error("Port 1 upper bits not zero");

    // Register contents on the release edge, before any write can land
    property p_reset_p0_regs;
        @(posedge MCLK) $rose(RST_N) |-> p0_cfg.data == `DPG_RST_P0_DATA && p0_cfg.dir == `DPG_RST_PORT_ZERO_DIRECTION
            && p0_cfg.alt == `DPG_RST_PORT_ZERO_ALTERNATE_SELECT && p0_cfg.drv == `DPG_RST_PORT_ZERO_DRIVE_STRENGTH;
    endproperty
    a_reset_p0_regs: assert property (p_reset_p0_regs) else $error("Port 0 reset values wrong");

    property p_reset_p1_regs;
        @(posedge MCLK) $rose(RST_N) |-> p1_cfg.data == `DPG_RST_P1_DATA && p1_cfg.dir == `DPG_RST_PORT_ONE_DIRECTION
            && p1_cfg.alt == `DPG_RST_PORT_ONE_ALTERNATE_SELECT;
    endproperty
    a_reset_p1_regs: assert property (p_reset_p1_regs) else $error("Port 1 reset values wrong");

    // Port 0 alternate functions
    property p_alt_inputs;
        @(posedge MCLK) disable iff (!RST_N) p0_cfg.alt[6:3] == 4'hf |=> P0_OE[6:3] == 4'h0;
    endproperty
    a_alt_inputs: assert property (p_alt_inputs) else $error("Input function pin driven");

    property p_rx_pass;
        @(posedge MCLK) disable iff (!RST_N) p0_cfg.alt[1] |=> UART_RX == $past(P0_IN[1]);
    endproperty
    a_rx_pass: assert property (p_rx_pass) else $error("Receive line not fed from pin");

    property p_int_b_gate;
        @(posedge MCLK) disable iff (!RST_N) !p0_cfg.alt[4] |=> EXTERNAL_INTERRUPT_B;
    endproperty
    a_int_b_gate: assert property (p_int_b_gate) else $error("Second interrupt passed without select");

    property p_int_pass;
        @(posedge MCLK) disable iff (!RST_N) p0_cfg.alt[3] && p0_cfg.alt[4]
            |=> EXTERNAL_INTERRUPT_A == $past(P0_IN[3]) && EXTERNAL_INTERRUPT_B == $past(P0_IN[4]);
    endproperty
    a_int_pass: assert property (p_int_pass) else $error("Interrupt pin not passed on");

    property p_timer_inputs;
        @(posedge MCLK) disable iff (!RST_N) p0_cfg.alt[5] && p0_cfg.alt[6]
            |=> TIMER_A_INPUT == $past(P0_IN[5]) && TIMER_B_INPUT == $past(P0_IN[6]);
    endproperty
    a_timer_inputs: assert property (p_timer_inputs) else $error("Timer input not fed from pin");

    property p_timer_pwm_out;
        @(posedge MCLK) disable iff (!RST_N) p0_cfg.alt[0] && p0_cfg.alt[7]
            |=> P0_OE[7] && P0_OUT[0] == $past(GENERAL_TIMER_OUTPUT) && P0_OUT[7] == $past(PWM_OUT);
    endproperty
    a_timer_pwm_out: assert property (p_timer_pwm_out) else $error("Timer or PWM pin not fed");

    property p_gpio_value;
        @(posedge MCLK) disable iff (!RST_N) !p0_cfg.alt[7] |=> P0_OUT[7] == $past(p0_cfg.data[7]);
    endproperty
    a_gpio_value: assert property (p_gpio_value) else $error("GPIO pin not fed by latch");

    // Port 1 routing
    property p_p1_latch_out;
        @(posedge MCLK) disable iff (!RST_N) SPI_ROUTE != `DPG_SPI_ROUTE_BOOT |=> P1_OUT == $past(p1_cfg.data);
    endproperty
    a_p1_latch_out: assert property (p_p1_latch_out) else $error("Port 1 not fed by latch");

    property p_p1_clock_gpio;
        @(posedge MCLK) disable iff (!RST_N) SPI_ROUTE != `DPG_SPI_ROUTE_BOOT && !p1_cfg.alt[0]
            |=> P1_OE[0] == !$past(p1_cfg.dir[0]) && !TIMER_C_INPUT;
    endproperty
    a_p1_clock_gpio: assert property (p_p1_clock_gpio) else $error("Clock pin not plain GPIO");

    property p_boot_select;
        @(posedge MCLK) disable iff (!RST_N) SPI_ROUTE == `DPG_SPI_ROUTE_BOOT
            |=> P1_OUT[3] == $past(p1_cfg.data[3]) && P1_OUT[1] == $past(SPI_MOSI);
    endproperty
    a_boot_select: assert property (p_boot_select) else $error("Select or data out pin wrong");

endmodule : dpg_gpio_top
`default_nettype wire

// File: dpg_pad_model.sv
// Pad and board model on the far side of both ports
`timescale 1ns/100ps
`default_nettype none

module dpg_pad_model (
    // Pad drive from the block
    input wire logic [7:0] p0_out,
    input wire logic [7:0] p0_oe,
    input wire logic [3:0] p1_out,
    input wire logic [3:0] p1_oe,
    // Far-side drive, taking effect only where the block lets go
    input wire logic [7:0] ext0,
    input wire logic [3:0] ext1,
    // Resolved pad levels
    output logic [7:0] p0_pad,
    output logic [3:0] p1_pad,
    // Select input of the boot memory
    output logic boot_memory_select
);
    // No pulls on these pads, so the bench changes ext every step to expose stale values
    assign p0_pad = (p0_oe & p0_out) | (~p0_oe & ext0);
    assign p1_pad = (p1_oe & p1_out) | (~p1_oe & ext1);
    assign boot_memory_select = p1_pad[3];
endmodule : dpg_pad_model

`default_nettype wire

// File: dpg_pkg.sv
// Types shared by the dual GPIO port block
`default_nettype none

package dpg_pkg;

    typedef struct packed {
        logic [7:0] data;
        logic [7:0] dir;
        logic [7:0] alt;
        logic [7:0] drv;
    } dpg_p0_cfg_t;

    typedef struct packed {
        logic [3:0] data;
        logic [3:0] dir;
        logic [3:0] alt;
    } dpg_p1_cfg_t;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
        logic timer_c_en;
    } dpg_p1_drive_t;

endpackage : dpg_pkg

`default_nettype wire

// File: dpg_port1_mux.sv
// Port 1 pin function selection between SPI master, timer input and GPIO
`timescale 1ns/100ps
`default_nettype none
`include "dpg_cfg.svh"

module dpg_port1_mux (
    // Routing and register state
    input wire logic [1:0] spi_route,
    input wire dpg_pkg::dpg_p1_cfg_t p1_cfg,
    // SPI engine outputs
    input wire logic spi_sck,
    input wire logic spi_mosi,
    // Pin drive decision
    output dpg_pkg::dpg_p1_drive_t drive
);

    always_comb begin
        drive.out = p1_cfg.data;
        drive.oe = ~p1_cfg.dir;
        drive.timer_c_en = 1'b0;
        if (spi_route == `DPG_SPI_ROUTE_BOOT) begin
            // SPI engine owns clock and data, select stays a GPIO latch bit
            drive.oe = `DPG_P1_SPI_OE;
            drive.out[`DPG_P1_SCK] = spi_sck;
            drive.out[`DPG_P1_MOSI] = spi_mosi;
        end else if (p1_cfg.alt[`DPG_P1_SCK]) begin
            drive.oe[`DPG_P1_SCK] = 1'b0;
            drive.timer_c_en = 1'b1;
        end
        // Outside the boot routing bits 1 and 3 keep their direction bits since they have no alternate use
        drive.oe[`DPG_P1_MISO] = 1'b0;
    end

endmodule : dpg_port1_mux
`default_nettype wire

// File: dpg_sfr_regs.sv
// Special function registers of both ports with registered read data
`timescale 1ns/100ps
`default_nettype none
`include "dpg_cfg.svh"

module dpg_sfr_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Special function register access
    input wire logic [7:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata,
    // Register contents
    output dpg_pkg::dpg_p0_cfg_t p0_cfg,
    output dpg_pkg::dpg_p1_cfg_t p1_cfg
);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            p0_cfg.data <= `DPG_RST_P0_DATA;
            p0_cfg.dir <= `DPG_RST_PORT_ZERO_DIRECTION;
            p0_cfg.alt <= `DPG_RST_PORT_ZERO_ALTERNATE_SELECT;
            p0_cfg.drv <= `DPG_RST_PORT_ZERO_DRIVE_STRENGTH;
        end else if (wr) begin
            case (addr)
                `DPG_ADDR_P0_DATA: p0_cfg.data <= wdata;
                `DPG_ADDR_PORT_ZERO_DIRECTION: p0_cfg.dir <= wdata;
                `DPG_ADDR_PORT_ZERO_ALTERNATE_SELECT: p0_cfg.alt <= wdata;
                `DPG_ADDR_PORT_ZERO_DRIVE_STRENGTH: p0_cfg.drv <= wdata;
                default: ;
            endcase
        end
    end

    // Only the low nibble exists on port 1
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            p1_cfg.data <= `DPG_RST_P1_DATA;
            p1_cfg.dir <= `DPG_RST_PORT_ONE_DIRECTION;
            p1_cfg.alt <= `DPG_RST_PORT_ONE_ALTERNATE_SELECT;
        end else if (wr) begin
            case (addr)
                `DPG_ADDR_P1_DATA: p1_cfg.data <= wdata[3:0];
                `DPG_ADDR_PORT_ONE_DIRECTION: p1_cfg.dir <= wdata[3:0];
                `DPG_ADDR_PORT_ONE_ALTERNATE_SELECT: p1_cfg.alt <= wdata[3:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                `DPG_ADDR_P0_DATA: rdata <= p0_cfg.data;
                `DPG_ADDR_PORT_ZERO_DIRECTION: rdata <= p0_cfg.dir;
                `DPG_ADDR_PORT_ZERO_ALTERNATE_SELECT: rdata <= p0_cfg.alt;
                `DPG_ADDR_PORT_ZERO_DRIVE_STRENGTH: rdata <= p0_cfg.drv;
                `DPG_ADDR_P1_DATA: rdata <= {4'h0, p1_cfg.data};
                `DPG_ADDR_PORT_ONE_DIRECTION: rdata <= {4'h0, p1_cfg.dir};
                `DPG_ADDR_PORT_ONE_ALTERNATE_SELECT: rdata <= {4'h0, p1_cfg.alt};
                default: rdata <= 8'h00;
            endcase
        end
    end

endmodule : dpg_sfr_regs
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the dual GPIO port block
`timescale 1ns/100ps
`default_nettype none
`include "dpg_cfg.svh"

module testbench;
    logic mclk, rst_n, sfr_wr, sfr_rd;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, p0_in, p0_out, p0_oe, p0_src, p0_snk, ext0;
    logic [3:0] p1_in, p1_out, p1_oe, ext1;
    logic [1:0] spi_route;
    logic gto, utx, pwm, sck, mosi, urx, ia, ib, ta, tb, tc, miso, bsel;
    logic [7:0] dir0, alt0, dat0, drv0;
    logic [3:0] dir1, alt1, dat1;
    logic [7:0] addrs [8] = '{8'h80, 8'h90, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97, 8'h91};
    int fails = 0;
    int compares = 0;
    int seed = 32'ha016;

    dpg_gpio_top dut_u (.MCLK(mclk), .RST_N(rst_n), .SFR_ADDR(sfr_addr), .SFR_WR(sfr_wr), .SFR_RD(sfr_rd),
        .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata), .SPI_ROUTE(spi_route), .P0_IN(p0_in), .P0_OUT(p0_out),
        .P0_OE(p0_oe), .P0_HI_SOURCE(p0_src), .P0_HI_SINK(p0_snk), .P1_IN(p1_in), .P1_OUT(p1_out),
        .P1_OE(p1_oe), .GENERAL_TIMER_OUTPUT(gto), .UART_TX(utx), .PWM_OUT(pwm), .SPI_SCK(sck),
        .SPI_MOSI(mosi), .UART_RX(urx), .EXTERNAL_INTERRUPT_A(ia), .EXTERNAL_INTERRUPT_B(ib),
        .TIMER_A_INPUT(ta), .TIMER_B_INPUT(tb), .TIMER_C_INPUT(tc), .SPI_MISO(miso));
    dpg_pad_model pads_u (.p0_out(p0_out), .p0_oe(p0_oe), .p1_out(p1_out), .p1_oe(p1_oe), .ext0(ext0),
        .ext1(ext1), .p0_pad(p0_in), .p1_pad(p1_in), .boot_memory_select(bsel));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : end_of_test

    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_byte

    task automatic chk_bit(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %b seen %b", what, exp, got);
        end
    endtask : chk_bit

    function automatic logic [7:0] rnd8();
        int r;
        r = $random(seed);
        return r[7:0];
    endfunction : rnd8

    // Timer output, transmit and PWM pins always drive under alternate; receive follows its direction bit
    function automatic logic [7:0] exp_p0_oe(input logic [7:0] dir, input logic [7:0] alt);
        return (alt & 8'h85) | (~alt & ~dir) | (alt & 8'h02 & ~dir);
    endfunction : exp_p0_oe

    function automatic logic [7:0] exp_p0_out();
        logic [7:0] v;
        v = dat0;
        if (alt0[0]) v[0] = gto;
        if (alt0[2]) v[2] = utx;
        if (alt0[7]) v[7] = pwm;
        return v;
    endfunction : exp_p0_out

    task automatic sfr_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge mclk);
        #2 sfr_addr = addr;
        sfr_wdata = data;
        sfr_wr = 1'b1;
        @(posedge mclk);
        #2 sfr_wr = 1'b0;
    endtask : sfr_write

    task automatic read_all;
        logic [7:0] exp [8];
        exp = '{dat0, {4'h0, dat1}, drv0, dir0, alt0, {4'h0, dir1}, {4'h0, alt1}, 8'h00};
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            #2 sfr_addr = addrs[i];
            sfr_rd = 1'b1;
            @(posedge mclk);
            #2 sfr_rd = 1'b0;
            chk_byte("sfr_rdata", exp[i], sfr_rdata);
        end
    endtask : read_all

    task automatic check_pins;
        logic [7:0] eoe, pin0;
        logic [3:0] eoe1, eout1, pin1;
        logic spi;
        eoe = exp_p0_oe(dir0, alt0);
        pin0 = (eoe & exp_p0_out()) | (~eoe & ext0);
        spi = (spi_route === `DPG_SPI_ROUTE_BOOT);
        eoe1 = spi ? 4'hb : {~dir1[3], 1'b0, ~dir1[1], ~dir1[0] & ~alt1[0]};
        eout1 = spi ? {dat1[3], 1'b0, mosi, sck} : dat1;
        pin1 = (eoe1 & eout1) | (~eoe1 & ext1);
        chk_byte("p0_oe", eoe, p0_oe);
        chk_byte("p0_out", exp_p0_out() & eoe, p0_out & eoe);
        chk_byte("p0_hi_source", drv0 & 8'haa, p0_src);
        chk_byte("p0_hi_sink", drv0 & 8'h55, p0_snk);
        chk_bit("uart_rx", alt0[1] ? pin0[1] : 1'b1, urx);
        chk_bit("interrupt_a", alt0[3] ? pin0[3] : 1'b1, ia);
        chk_bit("interrupt_b", alt0[4] ? pin0[4] : 1'b1, ib);
        chk_bit("timer_a", alt0[5] ? pin0[5] : 1'b0, ta);
        chk_bit("timer_b", alt0[6] ? pin0[6] : 1'b0, tb);
        chk_byte("p1_oe", {4'h0, eoe1}, {4'h0, p1_oe});
        chk_byte("p1_out", {4'h0, eout1 & eoe1}, {4'h0, p1_out & eoe1});
        chk_bit("timer_c", (!spi && alt1[0]) ? pin1[0] : 1'b0, tc);
        chk_bit("boot_select", pin1[3], bsel);
        if (spi)
            chk_bit("spi_miso", pin1[2], miso);
    endtask : check_pins

    task automatic set_reset_values;
        dat0 = `DPG_RST_P0_DATA;
        dir0 = `DPG_RST_PORT_ZERO_DIRECTION;
        alt0 = `DPG_RST_PORT_ZERO_ALTERNATE_SELECT;
        drv0 = `DPG_RST_PORT_ZERO_DRIVE_STRENGTH;
        dat1 = `DPG_RST_P1_DATA;
        dir1 = `DPG_RST_PORT_ONE_DIRECTION;
        alt1 = `DPG_RST_PORT_ONE_ALTERNATE_SELECT;
    endtask : set_reset_values

    initial begin
        #1_000_000;
        fails++;
        end_of_test();
    end

    initial begin
        logic [7:0] w [7];
        logic [7:0] ra, rb;
        rst_n = 1'b0;
        {sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = 18'h0_0000;
        spi_route = `DPG_SPI_ROUTE_BOOT;
        {gto, utx, pwm, sck, mosi} = 5'h15;
        ext0 = 8'h5a;
        ext1 = 4'h6;
        set_reset_values();
        repeat (3) @(posedge mclk);
        chk_byte("p0_oe_in_reset", 8'h00, p0_oe);
        chk_byte("p1_oe_in_reset", 8'h0b, {4'h0, p1_oe});
        #2 rst_n = 1'b1;
        repeat (5) @(posedge mclk);
        #2 check_pins();
        read_all();
        for (int n = 0; n < 40; n++) begin
            foreach (w[k]) w[k] = rnd8();
            // Corner cases first: every alternate bit against both direction extremes
            if (n < 2) begin
                w[3] = (n == 0) ? 8'h00 : 8'hff;
                w[4] = 8'hff;
                w[5] = {4'h0, w[3][3:0]};
                w[6] = 8'hff;
            end
            for (int i = 0; i < 7; i++) sfr_write(addrs[i], w[i]);
            {dat0, dat1, drv0, dir0, alt0, dir1, alt1} = {w[0], w[1][3:0], w[2], w[3], w[4], w[5][3:0], w[6][3:0]};
            ra = rnd8();
            rb = rnd8();
            {ext0, ext1, gto, utx, pwm, sck, mosi} = {rnd8(), ra[3:0], rb[4:0]};
            // First four passes walk every routing code, boot and radio included
            spi_route = (n < 4) ? n[1:0] : ra[7:6];
            repeat (3) @(posedge mclk);
            #2 check_pins();
            read_all();
        end
        @(posedge mclk);
        #2 rst_n = 1'b0;
        spi_route = `DPG_SPI_ROUTE_BOOT;
        set_reset_values();
        #3 chk_byte("p0_oe_async_reset", 8'h00, p0_oe);
        chk_byte("p1_oe_async_reset", 8'h0b, {4'h0, p1_oe});
        repeat (3) @(posedge mclk);
        #2 rst_n = 1'b1;
        repeat (3) @(posedge mclk);
        #2 check_pins();
        read_all();
        end_of_test();
    end
endmodule : testbench

`default_nettype wire
